/* hw/cpu_flow.sv */
// Flag register and program flow of an 8-bit core: fetch, traps, low power
// Assumes a combinational memory: i_mem_rdata answers o_mem_addr in-cycle
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_flow_defs.svh"
module cpu_flow
   import cpu_flow_pkg::*;
#(
   parameter int NIRQ = 4,
   parameter int STAB_CYCLES = `STAB_CYC
)
(
   input wire logic i_core_clk, // Bus clock, 50 MHz
   input wire logic i_rst, // Async reset, high
   input wire logic [7:0] i_mem_rdata, // Memory data for o_mem_addr
   input wire logic [NIRQ-1:0] i_irq_req, // Maskable requests, bit 0 first
   input wire logic i_brk_en, // Break module enabled
   input wire logic i_brk_req, // Break request level
   input wire logic i_monitor_mode, // Monitor vector select
   output logic [15:0] o_mem_addr, // Memory address
   output logic [7:0] o_mem_wdata, // Memory write data
   output logic o_mem_we, // Memory write strobe
   output logic o_clk_gate, // High while core clock is off
   output logic o_int_ack, // Vector fetch pulse
   output logic [7:0] o_flags, // Flag register
   output logic [15:0] o_ip, // Instruction pointer
   output logic [15:0] o_stack_ptr, // Stack pointer
   output logic [7:0] o_acc, // Accumulator
   output logic [15:0] o_index // Index register
);
   localparam int IW = (NIRQ > 1) ? $clog2(NIRQ) : 1;
   localparam logic [15:0] STAB_LAST = 16'(STAB_CYCLES - 1);

   // ****************
   // Priority decode
   // ****************
   function automatic logic [IW-1:0] prio_idx(input logic [NIRQ-1:0] req);
      logic [IW-1:0] idx;
      idx = '0;
      for (int k = NIRQ - 1; k >= 0; k--)
      begin
         if (req[k])
         begin
            idx = IW'(k);
         end
      end
      return idx;
   endfunction

   state_t state, next_state;
   logic [15:0] stack_ptr, next_stack_ptr;
   logic [7:0] flag_register, next_flag_register;
   logic [7:0] acc, next_acc, xl, next_xl, xh, next_xh;
   logic [7:0] opc, next_opc, opnd, next_opnd;
   logic [2:0] cnt, next_cnt;
   logic [15:0] vec, next_vec, bus_addr, next_bus_addr, stab_cnt, next_stab_cnt;
   logic [7:0] bus_wdata, next_bus_wdata;
   logic bus_we, next_bus_we, in_stop, next_in_stop, int_ack, next_int_ack;
   logic ip_inc, ip_load;
   logic [15:0] ip, ip_target, rel_target;
   alu_op_t alu_op;
   logic [7:0] alu_b, alu_res, alu_flags;
   logic brk_take, irq_take;
   logic [15:0] brk_vec, irq_vec;

   ip_unit u_ip (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_inc(ip_inc),
      .i_load(ip_load),
      .i_target(ip_target),
      .o_ip(ip)
   );

   flag_alu u_alu (
      .i_op(alu_op),
      .i_a(acc),
      .i_b(alu_b),
      .i_flags(flag_register),
      .o_res(alu_res),
      .o_flags(alu_flags)
   );

   assign brk_take = i_brk_en & i_brk_req;
   assign irq_take = ~flag_register[`FLG_I] & (|i_irq_req);
   assign brk_vec = i_monitor_mode ? `MON_TRAP_VEC : `TRAP_VEC;
   assign irq_vec = `IRQ_VEC_TOP - {{(15 - IW){1'b0}}, prio_idx(i_irq_req), 1'b0};
   assign rel_target = ip + {{8{opnd[7]}}, opnd};

   // ****************
   // Sequencer
   // ****************
   always_comb
   begin
      next_state = state;
      next_stack_ptr = stack_ptr;
      next_flag_register = flag_register;
      next_acc = acc;
      next_xl = xl;
      next_xh = xh;
      next_opc = opc;
      next_opnd = opnd;
      next_cnt = cnt;
      next_vec = vec;
      next_bus_addr = bus_addr;
      next_bus_wdata = bus_wdata;
      next_bus_we = 1'b0;
      next_in_stop = in_stop;
      next_stab_cnt = stab_cnt;
      next_int_ack = 1'b0;
      ip_inc = 1'b0;
      ip_load = 1'b0;
      ip_target = ip;
      alu_op = ALU_ADD;
      alu_b = opnd;
      case (state)
         S_FETCH:
         begin
            next_cnt = 3'h0;
            // Break wins over maskable requests; both only at a boundary
            if (brk_take || irq_take)
            begin
               next_vec = brk_take ? brk_vec : irq_vec;
               next_state = S_PUSH;
            end
            else
            begin
               ip_inc = 1'b1;
               next_opc = i_mem_rdata;
               next_bus_addr = ip + 16'h0001;
               case (i_mem_rdata)
                  `OP_SHL_A:
                  begin
                     alu_op = ALU_ASL;
                     alu_b = 8'h00;
                     next_acc = alu_res;
                     next_flag_register = alu_flags;
                  end
                  `OP_MASK_CLR:
                  begin
                     next_flag_register[`FLG_I] = 1'b0;
                  end
                  `OP_MASK_SET:
                  begin
                     next_flag_register[`FLG_I] = 1'b1;
                  end
                  `OP_PUSH_XH:
                  begin
                     next_bus_addr = stack_ptr;
                     next_bus_wdata = xh;
                     next_bus_we = 1'b1;
                     next_state = S_STORE;
                  end
                  `OP_PULL_XH:
                  begin
                     next_stack_ptr = stack_ptr + 16'h0001;
                     next_bus_addr = stack_ptr + 16'h0001;
                     next_state = S_LOAD_XH;
                  end
                  `OP_TRAP_RET:
                  begin
                     next_stack_ptr = stack_ptr + 16'h0001;
                     next_bus_addr = stack_ptr + 16'h0001;
                     next_state = S_PULL;
                  end
                  `OP_SOFT_TRAP:
                  begin
                     next_vec = i_monitor_mode ? `MON_TRAP_VEC : `TRAP_VEC;
                     next_state = S_PUSH;
                  end
                  `OP_WAIT, `OP_STOP:
                  begin
                     next_flag_register[`FLG_I] = 1'b0;
                     next_in_stop = (i_mem_rdata == `OP_STOP);
                     next_state = S_LOWPWR;
                  end
                  `OP_ADD_STK, `OP_BR_CC, `OP_ADD, `OP_ADC, `OP_AND:
                  begin
                     next_state = S_OPND;
                  end
                  default:
                  begin
                     next_state = S_FETCH;
                  end
               endcase
            end
         end
         S_OPND:
         begin
            ip_inc = 1'b1;
            next_opnd = i_mem_rdata;
            next_bus_addr = ip + 16'h0001;
            next_state = S_FETCH;
            case (opc)
               `OP_ADD_STK:
               begin
                  next_stack_ptr = stack_ptr + {{8{i_mem_rdata[7]}}, i_mem_rdata};
               end
               `OP_BR_CC:
               begin
                  next_state = S_BRANCH;
               end
               default:
               begin
                  alu_op = (opc == `OP_ADC) ? ALU_ADC : ((opc == `OP_AND) ? ALU_AND : ALU_ADD);
                  alu_b = i_mem_rdata;
                  next_acc = alu_res;
                  next_flag_register = alu_flags;
               end
            endcase
         end
         S_BRANCH:
         begin
            next_state = S_FETCH;
            next_bus_addr = ip;
            if (!flag_register[`FLG_C])
            begin
               ip_load = 1'b1;
               ip_target = rel_target;
               next_bus_addr = rel_target;
            end
         end
         S_PUSH:
         begin
            // Low pointer byte first so that pull order mirrors it
            if (cnt == `PUSH_BYTES)
            begin
               next_flag_register[`FLG_I] = 1'b1;
               next_bus_addr = vec;
               next_state = S_VEC_HI;
            end
            else
            begin
               next_bus_addr = stack_ptr;
               next_bus_we = 1'b1;
               next_stack_ptr = stack_ptr - 16'h0001;
               next_cnt = cnt + 3'h1;
               case (cnt)
                  3'h0: next_bus_wdata = ip[7:0];
                  3'h1: next_bus_wdata = ip[15:8];
                  3'h2: next_bus_wdata = xl;
                  3'h3: next_bus_wdata = acc;
                  default: next_bus_wdata = flag_register | `FLAGS_ONES;
               endcase
            end
         end
         S_VEC_HI:
         begin
            next_opnd = i_mem_rdata;
            next_bus_addr = bus_addr + 16'h0001;
            next_state = S_VEC_LO;
         end
         S_VEC_LO:
         begin
            ip_load = 1'b1;
            ip_target = {opnd, i_mem_rdata};
            next_bus_addr = {opnd, i_mem_rdata};
            next_int_ack = 1'b1;
            next_state = S_FETCH;
         end
         S_PULL:
         begin
            next_cnt = cnt + 3'h1;
            next_stack_ptr = stack_ptr + 16'h0001;
            next_bus_addr = stack_ptr + 16'h0001;
            case (cnt)
               3'h0: next_flag_register = i_mem_rdata;
               3'h1: next_acc = i_mem_rdata;
               3'h2: next_xl = i_mem_rdata;
               3'h3: next_opnd = i_mem_rdata;
               default:
               begin
                  next_stack_ptr = stack_ptr;
                  ip_load = 1'b1;
                  ip_target = {opnd, i_mem_rdata};
                  next_bus_addr = {opnd, i_mem_rdata};
                  next_state = S_FETCH;
               end
            endcase
         end
         S_STORE:
         begin
            next_stack_ptr = stack_ptr - 16'h0001;
            next_bus_addr = ip;
            next_state = S_FETCH;
         end
         S_LOAD_XH:
         begin
            next_xh = i_mem_rdata;
            next_bus_addr = ip;
            next_state = S_FETCH;
         end
         S_LOWPWR:
         begin
            next_bus_addr = ip;
            next_stab_cnt = 16'h0000;
            // Stop only wakes on the external request line
            if (in_stop && i_irq_req[0])
            begin
               next_state = S_STAB;
            end
            else if (!in_stop && ((|i_irq_req) || brk_take))
            begin
               next_state = S_FETCH;
            end
         end
         S_STAB:
         begin
            next_stab_cnt = stab_cnt + 16'h0001;
            if (stab_cnt == STAB_LAST)
            begin
               next_state = S_FETCH;
            end
         end
         default:
         begin
            next_state = S_FETCH;
         end
      endcase
   end

   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         state <= S_VEC_HI;
         bus_addr <= `RST_VEC;
         stack_ptr <= `STACK_RST;
         flag_register <= `FLAGS_RST;
         acc <= 8'h00;
         xl <= 8'h00;
         xh <= 8'h00;
         opc <= 8'h00;
         opnd <= 8'h00;
         cnt <= 3'h0;
         vec <= `TRAP_VEC;
         bus_wdata <= 8'h00;
         bus_we <= 1'b0;
         in_stop <= 1'b0;
         stab_cnt <= 16'h0000;
         int_ack <= 1'b0;
      end
      else
      begin
         state <= next_state;
         bus_addr <= next_bus_addr;
         stack_ptr <= next_stack_ptr;
         flag_register <= next_flag_register;
         acc <= next_acc;
         xl <= next_xl;
         xh <= next_xh;
         opc <= next_opc;
         opnd <= next_opnd;
         cnt <= next_cnt;
         vec <= next_vec;
         bus_wdata <= next_bus_wdata;
         bus_we <= next_bus_we;
         in_stop <= next_in_stop;
         stab_cnt <= next_stab_cnt;
         int_ack <= next_int_ack;
      end
   end

   assign o_mem_addr = bus_addr;
   assign o_mem_wdata = bus_wdata;
   assign o_mem_we = bus_we;
   assign o_clk_gate = (state == S_LOWPWR) || (state == S_STAB);
   assign o_int_ack = int_ack;
   assign o_flags = flag_register | `FLAGS_ONES;
   assign o_ip = ip;
   assign o_stack_ptr = stack_ptr;
   assign o_acc = acc;
   assign o_index = {xh, xl};

   // ****************
   // Checks
   // ****************
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   logic fetch_op;
   assign fetch_op = (state == S_FETCH) && !brk_take && !irq_take;

   reset_vector_a: assert property ($fell(i_rst) |->
      (o_mem_addr == `RST_VEC) ##1 (o_mem_addr == `RST_VEC + 16'h0001))
      else $error("reset vector not fetched high then low");
   flag_ones_a: assert property (o_flags[6:5] == 2'b11)
      else $error("flag bits 6 and 5 not one");
   // Soft trap is not maskable, so it is kept out of the antecedent
   mask_ignore_a: assert property ((state == S_FETCH && o_flags[`FLG_I] && !brk_take
      && i_mem_rdata != `OP_SOFT_TRAP) |=> (state != S_PUSH))
      else $error("masked request was taken");
   mask_after_stack_a: assert property ((state == S_PUSH && cnt == `PUSH_BYTES)
      |-> o_mem_we && (o_mem_wdata == o_flags)
      ##1 (o_flags[`FLG_I] && state == S_VEC_HI && o_mem_addr == vec))
      else $error("mask not set between stacking and vector fetch");
   trap_return_a: assert property ((state == S_PULL && cnt == 3'h0)
      |=> (o_flags[`FLG_I] == $past(i_mem_rdata[`FLG_I])))
      else $error("mask not restored from stack");
   shift_left_a: assert property ((fetch_op && i_mem_rdata == `OP_SHL_A)
      |=> (o_acc == {$past(o_acc[6:0]), 1'b0}) && (o_flags[`FLG_C] == $past(o_acc[7]))
      && (state == S_FETCH))
      else $error("accumulator shift wrong");
   add_stack_a: assert property ((fetch_op && i_mem_rdata == `OP_ADD_STK)
      |=> ##1 (o_stack_ptr == $past(o_stack_ptr, 2) + {{8{$past(i_mem_rdata[7])}},
      $past(i_mem_rdata)}) && (o_flags == $past(o_flags, 2)) && state == S_FETCH)
      else $error("stack add wrong");
   branch_cc_a: assert property ((fetch_op && i_mem_rdata == `OP_BR_CC && !o_flags[`FLG_C])
      |=> ##2 (state == S_FETCH) && (o_ip == $past(o_ip, 3) + 16'h0002
      + {{8{$past(i_mem_rdata[7], 2)}}, $past(i_mem_rdata, 2)}))
      else $error("carry clear branch target wrong");
   wait_entry_a: assert property ((fetch_op && i_mem_rdata == `OP_WAIT)
      |=> (!o_flags[`FLG_I] && o_clk_gate))
      else $error("wait entry wrong");
   break_vector_a: assert property ((state == S_FETCH && brk_take)
      |-> ##7 (o_mem_addr == $past(brk_vec, 7)) && (state == S_VEC_HI))
      else $error("break vector wrong");
   stop_wake_a: assert property ((state == S_LOWPWR && in_stop && i_irq_req[0])
      |=> (state == S_STAB) && (stab_cnt == 16'h0000) && o_clk_gate)
      else $error("stop wake did not wait for stabilisation");

   irq_entry_c: cover property (state == S_FETCH && irq_take && !brk_take);
   trap_return_c: cover property (state == S_PULL && cnt == 3'h4);
   stop_wake_c: cover property (state == S_STAB && stab_cnt == STAB_LAST);
   branch_taken_c: cover property (state == S_BRANCH && !o_flags[`FLG_C]);
endmodule
`default_nettype wire

/* hw/cpu_flow_defs.svh */
// Constants of the flag and program-flow core: vectors, flag bits, opcodes
// Assumes inclusion by bare name from hw/ files only
`ifndef CPU_FLOW_DEFS_SVH
`define CPU_FLOW_DEFS_SVH
// ****************
// Vectors and reset values
// ****************
`define RST_VEC 16'hFFFE
`define TRAP_VEC 16'hFFFC
`define MON_TRAP_VEC 16'hFEFC
`define IRQ_VEC_TOP 16'hFFFA
`define STACK_RST 16'h00FF
`define FLAGS_RST 8'h68
`define FLAGS_ONES 8'h60
`define PUSH_BYTES 3'h5
`define STAB_CYC 4096
// ****************
// Flag register bit positions
// ****************
`define FLG_V 7
`define FLG_H 4
`define FLG_I 3
`define FLG_N 2
`define FLG_Z 1
`define FLG_C 0
// ****************
// Opcodes
// ****************
`define OP_ADC 8'hA9
`define OP_ADD 8'hAB
`define OP_AND 8'hA4
`define OP_ADD_STK 8'hA7
`define OP_BR_CC 8'h24
`define OP_SHL_A 8'h48
`define OP_MASK_CLR 8'h9A
`define OP_MASK_SET 8'h9B
`define OP_TRAP_RET 8'h80
`define OP_SOFT_TRAP 8'h83
`define OP_WAIT 8'h8F
`define OP_STOP 8'h8E
`define OP_PUSH_XH 8'h8B
`define OP_PULL_XH 8'h8A
`endif

/* hw/cpu_flow_pkg.sv */
// Types shared by the flag and program-flow core
// Assumes nothing of its surroundings
package cpu_flow_pkg;
   typedef enum logic [10:0] {
      S_FETCH = 11'h001,
      S_OPND = 11'h002,
      S_BRANCH = 11'h004,
      S_PUSH = 11'h008,
      S_VEC_HI = 11'h010,
      S_VEC_LO = 11'h020,
      S_PULL = 11'h040,
      S_STORE = 11'h080,
      S_LOAD_XH = 11'h100,
      S_LOWPWR = 11'h200,
      S_STAB = 11'h400
   } state_t;
   typedef enum logic [3:0] {
      ALU_ADD = 4'h1,
      ALU_ADC = 4'h2,
      ALU_AND = 4'h4,
      ALU_ASL = 4'h8
   } alu_op_t;
endpackage

/* hw/flag_alu.sv */
// Combinational 8-bit ALU with flag update
// Assumes the accumulator and flags come from registers of the caller; the operand can be memory read data
`timescale 1ns/1ps
`default_nettype none
`include "cpu_flow_defs.svh"
module flag_alu
   import cpu_flow_pkg::*;
(
   input wire alu_op_t i_op, // Operation
   input wire logic [7:0] i_a, // Accumulator
   input wire logic [7:0] i_b, // Operand
   input wire logic [7:0] i_flags, // Flags before
   output logic [7:0] o_res, // Result
   output logic [7:0] o_flags // Flags after
);
   logic [8:0] sum;
   logic [4:0] half;
   logic cin;
   always_comb
   begin
      cin = (i_op == ALU_ADC) ? i_flags[`FLG_C] : 1'b0;
      sum = {1'b0, i_a} + {1'b0, i_b} + {8'h00, cin};
      half = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, cin};
      o_flags = i_flags;
      case (i_op)
         ALU_ADD, ALU_ADC:
         begin
            o_res = sum[7:0];
            o_flags[`FLG_C] = sum[8];
            o_flags[`FLG_H] = half[4];
            o_flags[`FLG_V] = (i_a[7] & i_b[7] & ~sum[7]) | (~i_a[7] & ~i_b[7] & sum[7]);
         end
         ALU_AND:
         begin
            o_res = i_a & i_b;
            o_flags[`FLG_V] = 1'b0;
         end
         ALU_ASL:
         begin
            o_res = {i_a[6:0], 1'b0};
            o_flags[`FLG_C] = i_a[7];
            o_flags[`FLG_V] = i_a[7] ^ i_a[6];
         end
         default:
         begin
            o_res = i_a;
         end
      endcase
      o_flags[`FLG_N] = o_res[7];
      o_flags[`FLG_Z] = (o_res == 8'h00);
   end
endmodule
`default_nettype wire

/* hw/ip_unit.sv */
// Instruction pointer register: sequential step or non-sequential load
// Assumes load and step are never asked in the same cycle
`timescale 1ns/1ps
`default_nettype none
module ip_unit
(
   input wire logic i_core_clk, // Core clock
   input wire logic i_rst, // Async reset, high
   input wire logic i_inc, // Step after a fetch
   input wire logic i_load, // Load target
   input wire logic [15:0] i_target, // Non-sequential address
   output logic [15:0] o_ip // Instruction pointer
);
   logic [15:0] next_ip;
   always_comb
   begin
      next_ip = o_ip;
      if (i_load)
      begin
         next_ip = i_target;
      end
      else if (i_inc)
      begin
         next_ip = o_ip + 16'h0001;
      end
   end
   always_ff @(posedge i_core_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_ip <= 16'h0000;
      end
      else
      begin
         o_ip <= next_ip;
      end
   end
   ip_step_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
      (i_inc && !i_load) |=> (o_ip == $past(o_ip) + 16'h0001))
      else $error("instruction pointer did not step");
   ip_load_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
      i_load |=> (o_ip == $past(i_target)))
      else $error("instruction pointer did not load target");
endmodule
`default_nettype wire

/* test/cpu_flags_and_program_flow_tb.sv */
// Testbench of the flag and program-flow core: runs a short program
// Assumes prog_mem answers the core's memory port in the same cycle
`timescale 1ns/1ps
`default_nettype none
module cpu_flags_and_program_flow_tb;
   import cpu_flow_pkg::*;
   logic clk = 0;
   logic rst = 1;
   logic [3:0] irq = 4'h6;
   logic brk_req = 0;
   logic mon = 0;
   logic [7:0] rdata, wdata, flags, acc;
   logic [15:0] addr, ip, sp, idx;
   logic we, gate, ack;
   int error_cnt = 0;
   int checks = 0;
   int n;
   // Unlisted bytes hold 9D, a one-cycle no-op
   logic [23:0] img [] = '{24'h0100_AB, 24'h0101_81, 24'h0103_48, 24'h0105_A9,
      24'h0106_0E, 24'h0108_24, 24'h0109_04, 24'h010E_A7, 24'h010F_FE, 24'h0111_9A,
      24'h0201_80, 24'h0300_8F, 24'h0400_8E, 24'hFFFE_01, 24'hFFFF_00, 24'hFFF8_02,
      24'hFFF9_00, 24'hFFF6_03, 24'hFFF7_00, 24'hFFFC_04, 24'hFFFD_00, 24'hFFFA_05,
      24'hFFFB_00, 24'h0500_A4, 24'h0501_00, 24'h0502_8A, 24'h0503_8A, 24'h0504_8B,
      24'h0505_8B, 24'h0506_9A, 24'h0507_9B, 24'h0508_83, 24'hFEFC_06, 24'hFEFD_00};
   always #10 clk = ~clk;
   cpu_flow #(.NIRQ(4), .STAB_CYCLES(8)) dut (.i_core_clk(clk), .i_rst(rst),
      .i_mem_rdata(rdata), .i_irq_req(irq), .i_brk_en(1'b1), .i_brk_req(brk_req),
      .i_monitor_mode(mon), .o_mem_addr(addr), .o_mem_wdata(wdata), .o_mem_we(we),
      .o_clk_gate(gate), .o_int_ack(ack), .o_flags(flags), .o_ip(ip),
      .o_stack_ptr(sp), .o_acc(acc), .o_index(idx));
   prog_mem pm (.i_core_clk(clk), .i_addr(addr), .i_wdata(wdata), .i_we(we),
      .o_rdata(rdata));
   // ****************
   // Tasks
   // ****************
   task chk(input string nm, input logic [39:0] got, input logic [39:0] exp);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Bounded: a missed target must not hang the run
   task wait_ip(input logic [15:0] a, output int c);
      c = 0;
      while (ip !== a && c < 300)
      begin
         @(negedge clk);
         c++;
      end
      chk("ip", ip, a);
   endtask
   task entry_chk(input logic [15:0] s);
      chk("ack", ack, 1'b1);
      chk("flags", flags, 8'h78);
      chk("sp", sp, s);
      chk("stack", {pm.m[s+1], pm.m[s+2], pm.m[s+3], pm.m[s+4], pm.m[s+5]},
         40'h70_1100_0112);
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      #100000;
      error_cnt++;
      print_verdict;
   end
   // ****************
   // Tests
   // ****************
   initial
   begin
      for (int i = 0; i < 65536; i++)
         pm.m[i] = 8'h9D;
      foreach (img[k])
         pm.m[img[k][23:8]] = img[k][7:0];
      @(negedge clk);
      chk("flags", flags, 8'h68);
      chk("sp", sp, 16'h00FF);
      chk("addr", addr, 16'hFFFE);
      repeat (20) @(posedge clk);
      rst <= 0;
      @(negedge clk);
      wait_ip(16'h0100, n);
      chk("vector cycles", n, 2);
      $display("reset test done");
      wait_ip(16'h0103, n);
      chk("add", {acc, flags}, 16'h816C);
      wait_ip(16'h0105, n);
      chk("shift", {acc, flags}, 16'h02E9);
      wait_ip(16'h0108, n);
      chk("adc", {acc, flags}, 16'h1178);
      wait_ip(16'h010E, n);
      chk("branch cycles", n, 3);
      wait_ip(16'h0110, n);
      chk("add sp cycles", n, 2);
      chk("add sp", {sp, flags}, 24'h00_FD78);
      $display("alu test done");
      wait_ip(16'h0112, n);
      wait_ip(16'h0200, n);
      chk("entry cycles", n, 9);
      entry_chk(16'h00F8);
      @(posedge clk);
      irq[1] <= 1'b0;
      wait_ip(16'h0300, n);
      entry_chk(16'h00F8);
      @(posedge clk);
      irq[2] <= 1'b0;
      $display("interrupt test done");
      repeat (4) @(negedge clk);
      chk("wait", {gate, flags[3]}, 2'b10);
      @(posedge clk);
      brk_req <= 1'b1;
      while (addr !== 16'hFFFD)
         @(negedge clk);
      @(posedge clk);
      brk_req <= 1'b0;
      @(negedge clk);
      wait_ip(16'h0400, n);
      chk("break wake", {gate, flags[3]}, 2'b01);
      repeat (4) @(negedge clk);
      chk("stop", {gate, flags[3]}, 2'b10);
      @(posedge clk);
      irq[0] <= 1'b1;
      wait_ip(16'h0500, n);
      chk("stop delay", n > 8, 1'b1);
      chk("sp", sp, 16'h00EE);
      $display("low power test done");
      // Handler: and, two pulls and two pushes of the high index, mask clear/set, soft trap
      @(posedge clk);
      irq[0] <= 1'b0;
      mon <= 1'b1;
      wait_ip(16'h0600, n);
      chk("index", {idx, pm.m[16'h00EF], pm.m[16'h00F0]}, 32'h1100_1111);
      chk("soft trap", {sp, flags, pm.m[16'h00EA], acc}, 40'h00_E97A_7A00);
      $display("trap test done");
      print_verdict;
   end
endmodule
`default_nettype wire

/* test/prog_mem.sv */
// Program memory model on the core's memory port
// Assumes address, data and strobe come from core registers
`timescale 1ns/1ps
`default_nettype none
module prog_mem
(
   input wire logic i_core_clk, // Core clock
   input wire logic [15:0] i_addr, // Address
   input wire logic [7:0] i_wdata, // Write data
   input wire logic i_we, // Write strobe
   output logic [7:0] o_rdata // Read data, same cycle
);
   // ****************
   // Storage
   // ****************
   logic [7:0] m [0:65535];
   // Same-cycle answer: the core has no wait states
   assign o_rdata = m[i_addr];
   always @(posedge i_core_clk)
   begin
      if (i_we)
      begin
         m[i_addr] <= i_wdata;
      end
   end
endmodule
`default_nettype wire
